// file: i2cpe_defines.svh
// Constants of the two-wire bus protocol engine: timing, first-byte codes.
// Assumes the link clock period below matches the clock on link_clk.
`ifndef I2CPE_DEFINES_SVH
`define I2CPE_DEFINES_SVH

`define I2CPE_LINK_PERIOD_NS 80
// Quarter of a 100 kbit/s bit period; each bit has four phases
`define I2CPE_QUARTER_NS 2500
`define I2CPE_QUARTER_CYC ((`I2CPE_QUARTER_NS + `I2CPE_LINK_PERIOD_NS - 1) / `I2CPE_LINK_PERIOD_NS)

`define I2CPE_TENBIT_MARK 5'h1E
`define I2CPE_GCALL_ADDR 7'h00
`define I2CPE_LEGACY_ADDR 7'h01
`define I2CPE_START_BYTE 8'h01
`define I2CPE_READ_DUMMY 8'hFF

// Address phases of a master transfer
`define I2CPE_APH_FIRST 2'h0
`define I2CPE_APH_LOW 2'h1
`define I2CPE_APH_REREAD 2'h2
`define I2CPE_APH_DATA 2'h3

`endif

// file: i2cpe_pkg.sv
// Types shared by the two-wire bus protocol engine.
// Assumes i2cpe_defines.svh sits beside it.
package i2cpe_pkg;

  // Settings from software, quasi-static: change only while enable is low
  typedef struct packed {
    logic enable;
    logic master;
    logic restart_en;
    logic addr_10bit;
    logic gcall_en;
    logic [9:0] target_addr;
    logic [6:0] slave_addr;
  } i2cpe_cfg_t;

  // One queued command: a write byte, or a read request
  typedef struct packed {
    logic read;
    logic [7:0] data;
  } i2cpe_cmd_t;

  typedef enum logic [2:0] {
    M_IDLE = 3'b000,
    M_START = 3'b001,
    M_BITS = 3'b011,
    M_RESTART = 3'b010,
    M_STOP = 3'b110
  } i2cpe_mstate_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_RX = 3'b001,
    S_HOLD = 3'b011,
    S_TX = 3'b010,
    S_SKIP = 3'b110
  } i2cpe_sstate_t;

endpackage

// file: i2cpe_engine.sv
// Two-wire bus protocol engine: master and 7-bit slave on open-drain pins.
// Assumes clk and link_clk are unrelated; bus-facing logic runs on link_clk,
// software side on clk. Pins need external pull-ups.
`timescale 1ns/100ps
`include "i2cpe_defines.svh"

module i2cpe_engine
  import i2cpe_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic link_clk,
  input wire i2cpe_cfg_t cfg,
  input wire logic tx_valid,
  input wire i2cpe_cmd_t tx_cmd,
  output logic tx_ready,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic gen_call,
  output logic rd_req,
  output logic tx_abort,
  output logic bus_busy,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe
);

  localparam logic [5:0] QUARTER = 6'(`I2CPE_QUARTER_CYC - 1);

  function automatic logic [7:0] addr_byte(input logic [1:0] aph, input logic rd,
                                           input i2cpe_cfg_t c);
    unique case (aph)
      `I2CPE_APH_FIRST: addr_byte = c.addr_10bit ?
        {`I2CPE_TENBIT_MARK, c.target_addr[9:8], 1'b0} : {c.target_addr[6:0], rd};
      `I2CPE_APH_LOW: addr_byte = c.target_addr[7:0];
      default: addr_byte = {`I2CPE_TENBIT_MARK, c.target_addr[9:8], 1'b1};
    endcase
  endfunction

  // Software side: one command slot, toggle handshake towards the link
  i2cpe_cmd_t tx_slot;
  logic tx_req;
  logic [1:0] ack_sync;
  logic tx_ack;
  wire accept = tx_valid & tx_ready;
  wire next_tx_req = tx_req ^ accept;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_req <= 1'b0;
      tx_slot <= '0;
      tx_ready <= 1'b0;
      ack_sync <= 2'b00;
    end else begin
      ack_sync <= {ack_sync[0], tx_ack};
      if (accept) begin
        tx_slot <= tx_cmd;
      end
      tx_req <= next_tx_req;
      // A stale acknowledge only delays ready, it never lets the slot be overwritten
      tx_ready <= (next_tx_req == ack_sync[1]);
    end
  end

  // Link reset: asserted at once, released in step with link_clk
  logic [1:0] lrst;
  wire lrst_n = lrst[1];
  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      lrst <= 2'b00;
    end else begin
      lrst <= {lrst[0], 1'b1};
    end
  end

  // Link side synchronisers
  i2cpe_cfg_t cfg_m, lcfg;
  logic [1:0] req_sync;
  logic [1:0] sda_sync, scl_sync;
  logic sda_d, scl_d;
  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      cfg_m <= '0;
      lcfg <= '0;
      req_sync <= 2'b00;
      sda_sync <= 2'b11;
      scl_sync <= 2'b11;
      sda_d <= 1'b1;
      scl_d <= 1'b1;
    end else begin
      cfg_m <= cfg;
      lcfg <= cfg_m;
      req_sync <= {req_sync[0], tx_req};
      sda_sync <= {sda_sync[0], sda_i};
      scl_sync <= {scl_sync[0], scl_i};
      sda_d <= sda_sync[1];
      scl_d <= scl_sync[1];
    end
  end

  wire sda_s = sda_sync[1];
  wire scl_s = scl_sync[1];
  wire start_det = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_det = scl_s & scl_d & ~sda_d & sda_s;
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  // The slot is held steady by the software side until the acknowledge returns
  wire pend = req_sync[1] ^ tx_ack;
  logic link_busy;

  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      link_busy <= 1'b0;
    end else if (start_det) begin
      link_busy <= 1'b1;
    end else if (stop_det) begin
      link_busy <= 1'b0;
    end
  end

  // Master sequencer
  i2cpe_mstate_t m_state;
  logic [5:0] qcnt;
  logic [1:0] ph;
  logic [3:0] m_bit;
  logic [1:0] aph;
  logic dir, nacked, m_sda, m_scl, m_take, m_push, m_abort;
  logic [7:0] m_sh, m_rx;
  wire [1:0] next_ph = ph + 2'd1;
  // Waits while another device stretches the clock low
  wire stall = (ph == 2'd2) && !m_scl && !scl_s;
  wire tick = (qcnt == 6'd0) && !stall;
  wire rd_data = (aph == `I2CPE_APH_DATA) && dir;

  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      m_state <= M_IDLE;
      qcnt <= QUARTER;
      ph <= 2'd0;
      m_bit <= 4'd0;
      aph <= `I2CPE_APH_FIRST;
      dir <= 1'b0;
      nacked <= 1'b0;
      m_sda <= 1'b0;
      m_scl <= 1'b0;
      m_sh <= 8'h00;
      m_rx <= 8'h00;
      m_take <= 1'b0;
      m_push <= 1'b0;
      m_abort <= 1'b0;
    end else begin
      m_take <= 1'b0;
      m_push <= 1'b0;
      m_abort <= 1'b0;
      if (!lcfg.enable || !lcfg.master) begin
        m_state <= M_IDLE;
        m_sda <= 1'b0;
        m_scl <= 1'b0;
        ph <= 2'd0;
        qcnt <= QUARTER;
      end else if (m_state == M_IDLE) begin
        ph <= 2'd0;
        qcnt <= QUARTER;
        if (pend && !link_busy && scl_s && sda_s && !m_take) begin
          m_state <= M_START;
          dir <= tx_slot.read;
          aph <= `I2CPE_APH_FIRST;
        end
      end else if (!tick) begin
        if (!stall) begin
          qcnt <= qcnt - 6'd1;
        end
      end else begin
        qcnt <= QUARTER;
        ph <= next_ph;
        unique case (m_state)
          M_START: begin
            if (next_ph == 2'd2) begin
              m_sda <= 1'b1;
            end
            if (next_ph == 2'd0) begin
              m_state <= M_BITS;
              m_scl <= 1'b1;
              m_bit <= 4'd0;
              m_sh <= addr_byte(aph, dir, lcfg);
            end
          end
          M_RESTART: begin
            if (next_ph == 2'd1) begin
              m_sda <= 1'b0;
            end
            if (next_ph == 2'd2) begin
              m_scl <= 1'b0;
            end
            if (next_ph == 2'd3) begin
              m_sda <= 1'b1;
            end
            if (next_ph == 2'd0) begin
              m_state <= M_BITS;
              m_scl <= 1'b1;
              m_bit <= 4'd0;
              m_sh <= addr_byte(aph, dir, lcfg);
            end
          end
          M_STOP: begin
            if (next_ph == 2'd1) begin
              m_sda <= 1'b1;
            end
            if (next_ph == 2'd2) begin
              m_scl <= 1'b0;
            end
            if (next_ph == 2'd3) begin
              m_sda <= 1'b0;
            end
            if (next_ph == 2'd0) begin
              m_state <= M_IDLE;
            end
          end
          M_BITS: begin
            if (next_ph == 2'd1) begin
              if (m_bit < 4'd8) begin
                m_sda <= ~m_sh[7];
              end else begin
                m_sda <= rd_data & pend & tx_slot.read & ~m_take;
              end
            end
            if (next_ph == 2'd2) begin
              m_scl <= 1'b0;
            end
            if (next_ph == 2'd3) begin
              if (m_bit < 4'd8) begin
                m_rx <= {m_rx[6:0], sda_s};
              end else begin
                nacked <= sda_s;
              end
            end
            if (next_ph == 2'd0) begin
              m_scl <= 1'b1;
              if (m_bit < 4'd8) begin
                m_bit <= m_bit + 4'd1;
                m_sh <= {m_sh[6:0], 1'b0};
              end else begin
                m_bit <= 4'd0;
                if (!rd_data && nacked) begin
                  m_state <= M_STOP;
                  m_abort <= 1'b1;
                  m_take <= pend;
                end else if (aph == `I2CPE_APH_FIRST && lcfg.addr_10bit) begin
                  aph <= `I2CPE_APH_LOW;
                  m_sh <= addr_byte(`I2CPE_APH_LOW, dir, lcfg);
                end else if (aph == `I2CPE_APH_LOW && dir) begin
                  m_state <= M_RESTART;
                  aph <= `I2CPE_APH_REREAD;
                end else if (aph != `I2CPE_APH_DATA) begin
                  aph <= `I2CPE_APH_DATA;
                  m_sh <= tx_slot.read ? `I2CPE_READ_DUMMY : tx_slot.data;
                  m_take <= 1'b1;
                end else begin
                  m_push <= dir;
                  if (!pend || m_take) begin
                    m_state <= M_STOP;
                  end else if (tx_slot.read != dir) begin
                    // Width is fixed per transfer chain; width switching is left out
                    m_state <= lcfg.restart_en ? M_RESTART : M_STOP;
                    aph <= `I2CPE_APH_FIRST;
                    dir <= tx_slot.read;
                  end else begin
                    m_sh <= tx_slot.read ? `I2CPE_READ_DUMMY : tx_slot.data;
                    m_take <= 1'b1;
                  end
                end
              end
            end
          end
          default: m_state <= M_IDLE;
        endcase
      end
    end
  end

  // Slave, 7-bit addressing, reacts to bus edges, and to a queued byte while it holds SCL
  i2cpe_sstate_t s_state;
  logic [3:0] s_bit;
  logic [7:0] s_sh;
  logic s_first, s_rd, s_nack, s_sda, s_scl, s_take, s_push, s_gc, s_rdreq;
  wire own_hit = (s_sh[7:1] == lcfg.slave_addr);
  wire gc_hit = (s_sh == {`I2CPE_GCALL_ADDR, 1'b0}) && lcfg.gcall_en;

  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      s_state <= S_IDLE;
      s_bit <= 4'd0;
      s_sh <= 8'h00;
      s_first <= 1'b0;
      s_rd <= 1'b0;
      s_nack <= 1'b0;
      s_sda <= 1'b0;
      s_scl <= 1'b0;
      s_take <= 1'b0;
      s_push <= 1'b0;
      s_gc <= 1'b0;
      s_rdreq <= 1'b0;
    end else begin
      s_take <= 1'b0;
      s_push <= 1'b0;
      s_gc <= 1'b0;
      s_rdreq <= 1'b0;
      if (!lcfg.enable || lcfg.master) begin
        s_state <= S_IDLE;
        s_sda <= 1'b0;
        s_scl <= 1'b0;
      end else if (stop_det) begin
        s_state <= S_IDLE;
        s_sda <= 1'b0;
        s_scl <= 1'b0;
      end else if (start_det) begin
        s_state <= S_RX;
        s_first <= 1'b1;
        s_bit <= 4'd0;
        s_sda <= 1'b0;
        s_scl <= 1'b0;
      end else begin
        unique case (s_state)
          S_IDLE, S_SKIP: s_sda <= 1'b0;
          S_RX: begin
            if (scl_rise) begin
              if (s_bit < 4'd8) begin
                s_sh <= {s_sh[6:0], sda_s};
              end
              s_bit <= s_bit + 4'd1;
            end
            if (scl_fall && s_bit == 4'd8) begin
              if (!s_first) begin
                s_sda <= 1'b1;
                s_push <= 1'b1;
              end else if (s_sh == `I2CPE_START_BYTE || s_sh[7:1] == `I2CPE_LEGACY_ADDR) begin
                s_state <= S_SKIP;
              end else if (own_hit || gc_hit) begin
                s_sda <= 1'b1;
                s_rd <= s_sh[0] & own_hit;
                s_gc <= gc_hit & ~own_hit;
              end else begin
                s_state <= S_SKIP;
              end
            end
            if (scl_fall && s_bit == 4'd9) begin
              s_sda <= 1'b0;
              s_bit <= 4'd0;
              s_first <= 1'b0;
              if (s_first && s_rd) begin
                s_state <= S_HOLD;
                s_scl <= 1'b1;
                s_rdreq <= 1'b1;
              end
            end
          end
          S_HOLD: begin
            // Data is placed while SCL is held, the clock is freed one cycle later
            if (pend && !s_take) begin
              s_sh <= tx_slot.data;
              s_sda <= ~tx_slot.data[7];
              s_take <= 1'b1;
              s_bit <= 4'd0;
              s_state <= S_TX;
            end
          end
          S_TX: begin
            s_scl <= 1'b0;
            if (scl_rise) begin
              s_bit <= s_bit + 4'd1;
              if (s_bit == 4'd8) begin
                s_nack <= sda_s;
              end
            end
            if (scl_fall) begin
              if (s_bit < 4'd8) begin
                s_sh <= {s_sh[6:0], 1'b0};
                s_sda <= ~s_sh[6];
              end else if (s_bit == 4'd8) begin
                s_sda <= 1'b0;
              end else if (s_nack) begin
                s_state <= S_SKIP;
              end else begin
                s_state <= S_HOLD;
                s_scl <= 1'b1;
                s_rdreq <= 1'b1;
              end
            end
          end
          default: s_state <= S_IDLE;
        endcase
      end
    end
  end

  // Link outputs and event toggles towards the software side
  logic [7:0] rx_word;
  logic [3:0] evt_tog;
  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      tx_ack <= 1'b0;
      rx_word <= 8'h00;
      evt_tog <= 4'h0;
      sda_oe <= 1'b0;
      scl_oe <= 1'b0;
      sda_o <= 1'b0;
      scl_o <= 1'b0;
    end else begin
      tx_ack <= tx_ack ^ (m_take | s_take);
      if (m_push) begin
        rx_word <= m_rx;
      end else if (s_push) begin
        rx_word <= s_sh;
      end
      evt_tog <= evt_tog ^ {m_push | s_push, s_gc, s_rdreq, m_abort};
      sda_oe <= m_sda | s_sda;
      scl_oe <= m_scl | s_scl;
      sda_o <= 1'b0;
      scl_o <= 1'b0;
    end
  end

  // Software side: toggles become one-cycle pulses
  logic [3:0] evt_s1, evt_s2, evt_d;
  logic [1:0] busy_sync;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      evt_s1 <= 4'h0;
      evt_s2 <= 4'h0;
      evt_d <= 4'h0;
      busy_sync <= 2'b00;
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
      gen_call <= 1'b0;
      rd_req <= 1'b0;
      tx_abort <= 1'b0;
      bus_busy <= 1'b0;
    end else begin
      evt_s1 <= evt_tog;
      evt_s2 <= evt_s1;
      evt_d <= evt_s2;
      busy_sync <= {busy_sync[0], link_busy};
      bus_busy <= busy_sync[1];
      rx_valid <= evt_s2[3] ^ evt_d[3];
      // rx_word is steady for a whole byte time after its toggle
      if (evt_s2[3] ^ evt_d[3]) begin
        rx_data <= rx_word;
      end
      gen_call <= evt_s2[2] ^ evt_d[2];
      rd_req <= evt_s2[1] ^ evt_d[1];
      tx_abort <= evt_s2[0] ^ evt_d[0];
    end
  end

endmodule

// file: i2cpe_engine_sva.sv
// Checker for the two-wire protocol engine, bound to its top ports.
// Assumes the bench models open-drain lines and no clock stretching.
`timescale 1ns/100ps
module i2cpe_engine_sva
  import i2cpe_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic link_clk,
  input wire i2cpe_cfg_t cfg,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic tx_abort,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe
);
  // A RESTART pulls data a quarter before the clock; only a START from a free clock counts
  sequence s_start_cond;
    cfg.master && scl_i && !scl_oe && !$past(scl_oe, 40) && $rose(sda_oe);
  endsequence
  sequence s_stop_cond;
    cfg.master && !scl_oe && $fell(sda_oe);
  endsequence

  a_start_then_low: assert property (@(posedge link_clk) disable iff (!reset_n)
    s_start_cond |-> ##[56:72] scl_oe) else $error("start not followed by clock low");
  a_stop_then_idle: assert property (@(posedge link_clk) disable iff (!reset_n)
    s_stop_cond |=> !scl_oe [*8]) else $error("clock pulled after stop");
  a_rise_sda_steady: assert property (@(posedge link_clk) disable iff (!reset_n)
    cfg.master && cfg.enable && $rose(scl_oe) |-> $stable(sda_oe))
    else $error("data moved with clock fall");
  a_fall_sda_steady: assert property (@(posedge link_clk) disable iff (!reset_n)
    cfg.master && cfg.enable && $fell(scl_oe) |-> $stable(sda_oe))
    else $error("data moved with clock release");
  a_pins_low_only: assert property (@(posedge link_clk) disable iff (!reset_n)
    !sda_o && !scl_o) else $error("pin driven high");
  a_slave_sda_quiet: assert property (@(posedge link_clk) disable iff (!reset_n)
    !cfg.master && cfg.enable && scl_i && $past(scl_i) |-> $stable(sda_oe))
    else $error("slave moved data while clock high");
  a_disabled_scl_free: assert property (@(posedge link_clk) disable iff (!reset_n)
    !cfg.enable [*8] ##1 !cfg.enable [*4] |-> !scl_oe)
    else $error("disabled engine holds clock");
  a_ready_drops: assert property (@(posedge clk) disable iff (!reset_n)
    tx_valid && tx_ready |=> !tx_ready) else $error("slot stayed free after accept");
  a_abort_pulse: assert property (@(posedge clk) disable iff (!reset_n)
    tx_abort |=> !tx_abort) else $error("abort longer than one cycle");
endmodule

// file: i2cpe_bus_slave.sv
// Behavioural slave on the two-wire bus; acks its own 7-bit address.
// Assumes the bench resolves the open-drain lines; never stretches SCL.
`timescale 1ns/100ps
module i2cpe_bus_slave #(
  parameter logic [6:0] ADDR = 7'h5A
) (
  input wire logic sda,
  input wire logic scl,
  output logic sda_oe,
  output logic [7:0] first_byte,
  output logic [7:0] last_byte,
  output int n_bytes
);
  logic [7:0] sh = 8'h00;
  int nb = 0;
  logic active = 1'b0;
  logic acked = 1'b0;
  initial begin
    sda_oe = 1'b0;
    first_byte = 8'h00;
    last_byte = 8'h00;
    n_bytes = 0;
  end
  always @(negedge sda) if (scl) begin
    active = 1'b1;
    nb = 0;
    n_bytes = 0;
  end
  always @(posedge sda) if (scl) active = 1'b0;
  always @(posedge scl) if (active && nb < 8) begin
    sh = {sh[6:0], sda};
    nb = nb + 1;
  end
  // Drives only after SCL falls, so SDA never moves while SCL is high
  always @(negedge scl) begin
    if (active && nb == 8) begin
      if (n_bytes == 0) first_byte = sh;
      last_byte = sh;
      n_bytes = n_bytes + 1;
      acked = (n_bytes > 1) || (sh[7:1] == ADDR);
      sda_oe <= acked;
      nb = 9;
    end else if (active && nb == 9) begin
      sda_oe <= 1'b0;
      nb = 0;
      if (!acked) active = 1'b0;
    end
  end
endmodule

// file: testbench.sv
// Self-checking bench: master writes to a modelled slave, slave idle, disable.
// Assumes package, engine, checker and slave model are compiled before it.
`timescale 1ns/100ps
module testbench
  import i2cpe_pkg::*;
;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic reset_n = 1'b0;
  i2cpe_cfg_t cfg = '0;
  logic tx_valid = 1'b0;
  i2cpe_cmd_t tx_cmd = '0;
  logic tx_ready, rx_valid, gen_call, rd_req, tx_abort, bus_busy;
  logic sda_o, sda_oe, scl_o, scl_oe, p_oe;
  logic [7:0] rx_data, p_first, p_last;
  logic abort_seen = 1'b0;
  logic evt_seen = 1'b0;
  int p_count;
  int err_total = 0;
  int n_compared = 0;
  int cycles = 0;
  wire sda_w = !(sda_oe || p_oe);
  wire scl_w = !scl_oe;
  logic [6:0] row_addr [2] = '{7'h5A, 7'h33};
  logic [7:0] row_data [2] = '{8'hA5, 8'hC3};
  logic row_ack [2] = '{1'b1, 1'b0};

  initial begin
    forever #2.5 clk = !clk;
  end
  // First link edge falls inside the short reset so the link side is cleared too
  initial begin
    #13;
    forever begin
      link_clk = !link_clk;
      #40;
    end
  end

  i2cpe_engine dut (.clk(clk), .reset_n(reset_n), .link_clk(link_clk), .cfg(cfg),
    .tx_valid(tx_valid), .tx_cmd(tx_cmd), .tx_ready(tx_ready), .rx_valid(rx_valid),
    .rx_data(rx_data), .gen_call(gen_call), .rd_req(rd_req), .tx_abort(tx_abort),
    .bus_busy(bus_busy), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
    .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe));
  i2cpe_bus_slave #(.ADDR(7'h5A)) partner (.sda(sda_w), .scl(scl_w), .sda_oe(p_oe),
    .first_byte(p_first), .last_byte(p_last), .n_bytes(p_count));

  always @(posedge clk) begin
    if (tx_abort === 1'b1) abort_seen <= 1'b1;
    if (rx_valid !== 1'b0 || gen_call !== 1'b0 || rd_req !== 1'b0) evt_seen <= 1'b1;
    cycles <= cycles + 1;
    if (cycles == 95000) begin
      err_total = err_total + 1;
      $display("MISMATCH %0t: timeout", $time);
      results();
    end
  end

  task automatic check(input logic ok, input string what);
    n_compared++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("MISMATCH %0t: %s", $time, what);
    end
  endtask
  task automatic results();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Settings are only changed while the engine is off
  task automatic setup(input logic mst, input logic [9:0] addr);
    cfg.enable = 1'b0;
    repeat (80) @(negedge clk);
    cfg = '{1'b0, mst, 1'b1, 1'b0, 1'b0, addr, 7'h11};
    repeat (80) @(negedge clk);
    cfg.enable = 1'b1;
  endtask
  task automatic send(input logic [7:0] d);
    tx_cmd = {1'b0, d};
    tx_valid = 1'b1;
    @(posedge clk);
    while (tx_ready !== 1'b1) @(posedge clk);
    @(negedge clk);
    tx_valid = 1'b0;
  endtask
  task automatic wait_busy(input logic lvl, input int limit);
    int k;
    k = 0;
    while (bus_busy !== lvl && k < limit) begin
      @(negedge clk);
      k++;
    end
    check(bus_busy === lvl, "bus busy level");
  endtask

  initial begin
    repeat (6) @(posedge clk);
    check(sda_oe === 1'b0 && scl_oe === 1'b0 && tx_ready === 1'b0, "reset outputs");
    @(negedge clk);
    reset_n = 1'b1;
    setup(1'b0, 10'h000);
    repeat (400) @(negedge clk);
    check(sda_oe === 1'b0 && scl_oe === 1'b0 && bus_busy === 1'b0, "idle slave");
    for (int i = 0; i < 2; i++) begin
      setup(1'b1, {3'h0, row_addr[i]});
      abort_seen = 1'b0;
      evt_seen = 1'b0;
      send(row_data[i]);
      wait_busy(1'b1, 3000);
      wait_busy(1'b0, 45000);
      repeat (20) @(negedge clk);
      check(p_first === {row_addr[i], 1'b0}, "first byte");
      check(p_count == (row_ack[i] ? 2 : 1), "byte count");
      check(!row_ack[i] || p_last === row_data[i], "data byte");
      check(abort_seen === !row_ack[i], "abort flag");
      check(tx_ready === 1'b1, "slot free after stop");
      check(evt_seen === 1'b0 && rx_data === 8'h00, "receive event in master write");
    end
    // Disable in mid-address: the clock line must come free
    setup(1'b1, {3'h0, row_addr[0]});
    send(8'h3C);
    wait_busy(1'b1, 3000);
    repeat (3000) @(negedge clk);
    cfg.enable = 1'b0;
    repeat (300) @(negedge clk);
    check(scl_oe === 1'b0, "disabled engine frees clock");
    results();
  end
endmodule

bind i2cpe_engine i2cpe_engine_sva chk (.clk(clk), .reset_n(reset_n), .link_clk(link_clk),
  .cfg(cfg), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_abort(tx_abort), .sda_o(sda_o),
  .sda_oe(sda_oe), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe));
